// [core/l1c_params.svh]
// l1c_params.svh: constants shared by the split level-one cache files.
// Assumes 32-bit byte addresses, word-wide core ports and a word-wide system bus.
`ifndef L1C_PARAMS_SVH
`define L1C_PARAMS_SVH
`define L1C_IC_BYTES 16384
`define L1C_DC_BYTES 4096
`define L1C_TAG_W 22
`define L1C_SETS 64
`define L1C_SET_W 6
`define L1C_LINE_WORDS 4
`define L1C_OFS_W 2
`define L1C_WORD_BYTES 4
`define L1C_WORD_LSB 2
`define L1C_SET_LSB 4
`define L1C_TAG_LSB 10
`define L1C_BE_ALL 4'hf
`endif

// [core/l1c_pkg.sv]
// l1c_pkg: types shared by the split cache, its tag arrays and their interface.
// Assumes l1c_params.svh sits on the include path.
`include "l1c_params.svh"
package l1c_pkg;
  typedef logic [`L1C_TAG_W-1:0] l1c_tag_t;
  typedef logic [`L1C_SET_W-1:0] l1c_set_t;
  typedef logic [31:0] l1c_word_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOOK = 3'b001,
    ST_WB = 3'b010,
    ST_FILL = 3'b011,
    ST_UNC = 3'b100,
    ST_LFBW = 3'b101
  } l1c_state_t;
  typedef enum logic [1:0] {
    SRC_IF = 2'b00,
    SRC_LS = 2'b01,
    SRC_CM = 2'b10
  } l1c_src_t;
endpackage

// [core/l1c_split_cache.sv]
// l1c_split_cache: split level-one instruction and data caches with per-line locking.
// Assumes the core issues one-cycle requests only while ready_out is high and that
// the system bus answers every word request with a one-cycle bus_ack_in.
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "l1c_params.svh"
module l1c_split_cache #(
  parameter int IC_BYTES = `L1C_IC_BYTES,
  parameter int DC_BYTES = `L1C_DC_BYTES
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  output logic ready_out,
  input wire logic if_req_in,
  input wire l1c_pkg::l1c_word_t if_va_in,
  input wire l1c_pkg::l1c_word_t if_pa_in,
  output logic if_ack_out,
  output l1c_pkg::l1c_word_t if_data_out,
  input wire logic ls_req_in,
  input wire logic ls_we_in,
  input wire logic [3:0] ls_be_in,
  input wire l1c_pkg::l1c_word_t ls_va_in,
  input wire l1c_pkg::l1c_word_t ls_pa_in,
  input wire l1c_pkg::l1c_word_t ls_wdata_in,
  output logic ls_ack_out,
  output l1c_pkg::l1c_word_t ls_rdata_out,
  output logic ls_perr_out,
  input wire logic cm_req_in,
  input wire logic cm_dside_in,
  input wire logic cm_lock_in,
  input wire l1c_pkg::l1c_word_t cm_va_in,
  input wire l1c_pkg::l1c_word_t cm_pa_in,
  output logic cm_ack_out,
  output logic cm_hit_out,
  output logic bus_req_out,
  output logic bus_we_out,
  output logic [3:0] bus_be_out,
  output l1c_pkg::l1c_word_t bus_addr_out,
  output l1c_pkg::l1c_word_t bus_wdata_out,
  input wire logic bus_ack_in,
  input wire l1c_pkg::l1c_word_t bus_rdata_in
);
  import l1c_pkg::*;
  localparam int LINE_BYTES = `L1C_LINE_WORDS * `L1C_WORD_BYTES;
  localparam int IWAYS = IC_BYTES / (`L1C_SETS * LINE_BYTES);
  localparam int DWAYS = DC_BYTES / (`L1C_SETS * LINE_BYTES);
  localparam int IWW = (IWAYS > 1) ? $clog2(IWAYS) : 1;
  localparam int DWW = (DWAYS > 1) ? $clog2(DWAYS) : 1;
  localparam int OW = `L1C_OFS_W;
  localparam int IAW = IWW + `L1C_SET_W + OW;
  localparam int DAW = DWW + `L1C_SET_W + OW;

  function automatic logic [3:0] par4(input l1c_word_t w);
    for (int b = 0; b < 4; b++) begin
      par4[b] = ^w[8*b +: 8];
    end
  endfunction

  l1c_state_t st_q, st_d;
  l1c_src_t src_q;
  logic we_q, dside_q, lkop_q;
  logic [3:0] be_q;
  l1c_word_t wdata_q;
  l1c_set_t set_q;
  l1c_tag_t ptag_q;
  logic [OW-1:0] word_q, beat_q, beat_d;
  logic [DWW-1:0] dvic_q;
  l1c_tag_t dvtag_q;

  l1c_word_t iarr [2**IAW];
  l1c_word_t darr [2**DAW];
  logic [3:0] dpar [2**DAW];
  logic [IWAYS-1:0] iuse_q [`L1C_SETS];
  logic [DWAYS-1:0] duse_q [`L1C_SETS];
  logic [DWAYS-1:0] ddirty_q [`L1C_SETS];

  l1c_word_t lfb_q [`L1C_LINE_WORDS];
  logic lfb_full_q;
  l1c_set_t lfb_set_q;
  l1c_tag_t lfb_tag_q;
  logic [IWW-1:0] lfb_way_q;

  logic ready_q, if_ack_q, ls_ack_q, ls_perr_q, cm_ack_q, cm_hit_q;
  l1c_word_t if_data_q, ls_rdata_q, bus_addr_q, bus_wdata_q;
  logic bus_req_q, bus_we_q;
  logic [3:0] bus_be_q;

  logic take, look, isd, hit, vic_ok, lfb_hit, needflush, miss;
  logic ihit_rd, lfbhit_rd, dhit, cm_do, fill_beat, fill_end, d_wb;
  logic [IAW-1:0] iidx;
  logic [DAW-1:0] didx;
  logic [DWW-1:0] dvic_cur;
  l1c_tag_t dvtag_cur;
  l1c_word_t merged;
  logic [IWAYS-1:0] iuse_new;
  logic [DWAYS-1:0] duse_new;

  l1c_tag_if #(.WAYS(IWAYS)) itif ();
  l1c_tag_if #(.WAYS(DWAYS)) dtif ();

  l1c_tag_array #(.WAYS(IWAYS)) u_itag (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .tif(itif)
  );

  l1c_tag_array #(.WAYS(DWAYS)) u_dtag (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .tif(dtif)
  );

  // Lookup decisions, made in ST_LOOK: the cycle after capture, after a buffer flush and after a data refill
  assign take = (st_q == ST_IDLE) && (if_req_in || ls_req_in || cm_req_in);
  assign look = (st_q == ST_LOOK);
  assign isd = (src_q == SRC_LS) || ((src_q == SRC_CM) && dside_q);
  assign hit = isd ? dtif.hit : itif.hit;
  assign vic_ok = isd ? dtif.vic_ok : itif.vic_ok;
  assign lfb_hit = (src_q == SRC_IF) && lfb_full_q && (lfb_set_q == set_q)
                   && (lfb_tag_q == ptag_q);
  // Buffer must land in the array before a new instruction fill or lock change
  assign needflush = look && !isd && lfb_full_q && !lfb_hit
                     && !((src_q == SRC_IF) && itif.hit);
  assign miss = look && !needflush && !hit && !lfb_hit && (src_q != SRC_CM);
  assign ihit_rd = look && (src_q == SRC_IF) && !lfb_hit && itif.hit;
  assign lfbhit_rd = look && lfb_hit;
  assign dhit = look && (src_q == SRC_LS) && dtif.hit;
  assign cm_do = look && (src_q == SRC_CM) && !needflush;
  assign fill_beat = (st_q == ST_FILL) && bus_ack_in;
  assign fill_end = fill_beat && (&beat_q);
  assign d_wb = dtif.vic_valid && ddirty_q[set_q][dtif.vic_way];
  assign iidx = {itif.hit_way, set_q, word_q};
  assign didx = {dtif.hit_way, set_q, word_q};
  assign dvic_cur = look ? dtif.vic_way : dvic_q;
  assign dvtag_cur = look ? dtif.vic_tag : dvtag_q;

  assign itif.rd_set = set_q;
  assign itif.rd_tag = ptag_q;
  assign itif.use_bits = iuse_q[set_q];
  assign itif.wr_en = (st_q == ST_LFBW);
  assign itif.wr_way = lfb_way_q;
  assign itif.wr_set = lfb_set_q;
  assign itif.wr_tag = lfb_tag_q;
  assign itif.lk_en = cm_do && !dside_q;
  assign itif.lk_val = lkop_q;
  assign dtif.rd_set = set_q;
  assign dtif.rd_tag = ptag_q;
  assign dtif.use_bits = duse_q[set_q];
  assign dtif.wr_en = fill_end && isd;
  assign dtif.wr_way = dvic_q;
  assign dtif.wr_set = set_q;
  assign dtif.wr_tag = ptag_q;
  assign dtif.lk_en = cm_do && dside_q;
  assign dtif.lk_val = lkop_q;

  // Store merge; lock bit is not consulted on a store hit
  always_comb begin
    merged = darr[didx];
    for (int b = 0; b < 4; b++) begin
      if (be_q[b]) begin
        merged[8*b +: 8] = wdata_q[8*b +: 8];
      end
    end
  end

  // Not-recently-used update: mark the way, restart when every way is marked
  always_comb begin
    // A buffer flush updates the buffered line's set, not the pending request's
    iuse_new = iuse_q[st_q == ST_LFBW ? lfb_set_q : set_q];
    iuse_new[st_q == ST_LFBW ? lfb_way_q : itif.hit_way] = 1'b1;
    if (&iuse_new) begin
      iuse_new = '0;
      iuse_new[st_q == ST_LFBW ? lfb_way_q : itif.hit_way] = 1'b1;
    end
    duse_new = duse_q[set_q];
    duse_new[dtif.hit_way] = 1'b1;
    if (&duse_new) begin
      duse_new = '0;
      duse_new[dtif.hit_way] = 1'b1;
    end
  end

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (take) begin
          st_d = ST_LOOK;
        end
      end
      ST_LOOK: begin
        if (needflush) begin
          st_d = ST_LFBW;
        end else if (miss && !vic_ok) begin
          st_d = ST_UNC;
        end else if (miss && isd && d_wb) begin
          st_d = ST_WB;
        end else if (miss) begin
          st_d = ST_FILL;
        end else begin
          st_d = ST_IDLE;
        end
      end
      ST_WB: begin
        if (bus_ack_in && (&beat_q)) begin
          st_d = ST_FILL;
        end
      end
      ST_FILL: begin
        if (fill_end) begin
          st_d = isd ? ST_LOOK : ST_IDLE;
        end
      end
      ST_UNC: begin
        if (bus_ack_in) begin
          st_d = ST_IDLE;
        end
      end
      ST_LFBW: st_d = ST_LOOK;
      default: st_d = ST_IDLE;
    endcase
  end

  always_comb begin
    if (st_d != st_q) begin
      beat_d = '0;
    end else if (bus_ack_in) begin
      beat_d = beat_q + 1'b1;
    end else begin
      beat_d = beat_q;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q <= ST_IDLE;
      beat_q <= '0;
      ready_q <= 1'b0;
      dvic_q <= '0;
      dvtag_q <= '0;
    end else begin
      st_q <= st_d;
      beat_q <= beat_d;
      ready_q <= (st_d == ST_IDLE);
      if (look) begin
        dvic_q <= dtif.vic_way;
        dvtag_q <= dtif.vic_tag;
      end
    end
  end

  // Set from virtual address, tag from the translation of the same cycle
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      src_q <= SRC_IF;
      we_q <= 1'b0;
      dside_q <= 1'b0;
      lkop_q <= 1'b0;
      be_q <= '0;
      wdata_q <= '0;
      set_q <= '0;
      word_q <= '0;
      ptag_q <= '0;
    end else if (take) begin
      we_q <= 1'b0;
      if (cm_req_in) begin
        src_q <= SRC_CM;
        dside_q <= cm_dside_in;
        lkop_q <= cm_lock_in;
        set_q <= cm_va_in[`L1C_SET_LSB +: `L1C_SET_W];
        word_q <= cm_va_in[`L1C_WORD_LSB +: OW];
        ptag_q <= cm_pa_in[`L1C_TAG_LSB +: `L1C_TAG_W];
      end else if (ls_req_in) begin
        src_q <= SRC_LS;
        we_q <= ls_we_in;
        be_q <= ls_we_in ? ls_be_in : `L1C_BE_ALL;
        wdata_q <= ls_wdata_in;
        set_q <= ls_va_in[`L1C_SET_LSB +: `L1C_SET_W];
        word_q <= ls_va_in[`L1C_WORD_LSB +: OW];
        ptag_q <= ls_pa_in[`L1C_TAG_LSB +: `L1C_TAG_W];
      end else begin
        src_q <= SRC_IF;
        be_q <= `L1C_BE_ALL;
        set_q <= if_va_in[`L1C_SET_LSB +: `L1C_SET_W];
        word_q <= if_va_in[`L1C_WORD_LSB +: OW];
        ptag_q <= if_pa_in[`L1C_TAG_LSB +: `L1C_TAG_W];
      end
    end
  end

  // Fill buffer gathers the whole line; array write waits for the next flush
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lfb_full_q <= 1'b0;
      lfb_set_q <= '0;
      lfb_tag_q <= '0;
      lfb_way_q <= '0;
    end else begin
      if (miss && !isd && vic_ok) begin
        lfb_set_q <= set_q;
        lfb_tag_q <= ptag_q;
        lfb_way_q <= itif.vic_way;
      end
      if (fill_end && !isd) begin
        lfb_full_q <= 1'b1;
      end else if (st_q == ST_LFBW) begin
        lfb_full_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (fill_beat && !isd) begin
      lfb_q[beat_q] <= bus_rdata_in;
    end
    if (st_q == ST_LFBW) begin
      for (int w = 0; w < `L1C_LINE_WORDS; w++) begin
        iarr[{lfb_way_q, lfb_set_q, OW'(w)}] <= lfb_q[w];
      end
    end
    if (fill_beat && isd) begin
      darr[{dvic_q, set_q, beat_q}] <= bus_rdata_in;
      dpar[{dvic_q, set_q, beat_q}] <= par4(bus_rdata_in);
    end else if (dhit && we_q) begin
      darr[didx] <= merged;
      dpar[didx] <= par4(merged);
    end
  end

  // Dirty and replacement bits per set, kept apart from the tags
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int s = 0; s < `L1C_SETS; s++) begin
        iuse_q[s] <= '0;
        duse_q[s] <= '0;
        ddirty_q[s] <= '0;
      end
    end else begin
      if (ihit_rd || (st_q == ST_LFBW)) begin
        iuse_q[st_q == ST_LFBW ? lfb_set_q : set_q] <= iuse_new;
      end
      if (dhit) begin
        duse_q[set_q] <= duse_new;
      end
      if (dhit && we_q) begin
        ddirty_q[set_q][dtif.hit_way] <= 1'b1;
      end else if (fill_end && isd) begin
        ddirty_q[set_q][dvic_q] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      if_ack_q <= 1'b0;
      if_data_q <= '0;
      ls_ack_q <= 1'b0;
      ls_rdata_q <= '0;
      ls_perr_q <= 1'b0;
      cm_ack_q <= 1'b0;
      cm_hit_q <= 1'b0;
    end else begin
      if_ack_q <= 1'b0;
      ls_ack_q <= 1'b0;
      cm_ack_q <= 1'b0;
      if (lfbhit_rd) begin
        if_ack_q <= 1'b1;
        if_data_q <= lfb_q[word_q];
      end else if (ihit_rd) begin
        if_ack_q <= 1'b1;
        if_data_q <= iarr[iidx];
      end else if (fill_beat && !isd && (beat_q == word_q)) begin
        if_ack_q <= 1'b1;
        if_data_q <= bus_rdata_in;
      end else if ((st_q == ST_UNC) && bus_ack_in && (src_q == SRC_IF)) begin
        if_ack_q <= 1'b1;
        if_data_q <= bus_rdata_in;
      end
      if (dhit) begin
        ls_ack_q <= 1'b1;
        ls_rdata_q <= we_q ? ls_rdata_q : darr[didx];
        ls_perr_q <= !we_q && (par4(darr[didx]) != dpar[didx]);
      end else if ((st_q == ST_UNC) && bus_ack_in && (src_q == SRC_LS)) begin
        ls_ack_q <= 1'b1;
        ls_rdata_q <= we_q ? ls_rdata_q : bus_rdata_in;
        ls_perr_q <= 1'b0;
      end
      if (cm_do) begin
        cm_ack_q <= 1'b1;
        cm_hit_q <= hit;
      end
    end
  end

  // One word per request; address and data follow the beat about to be presented
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bus_req_q <= 1'b0;
      bus_we_q <= 1'b0;
      bus_be_q <= '0;
      bus_addr_q <= '0;
      bus_wdata_q <= '0;
    end else begin
      bus_req_q <= (st_d == ST_WB) || (st_d == ST_FILL) || (st_d == ST_UNC);
      bus_be_q <= `L1C_BE_ALL;
      bus_we_q <= 1'b0;
      if (st_d == ST_WB) begin
        bus_we_q <= 1'b1;
        bus_addr_q <= {dvtag_cur, set_q, beat_d, 2'b00};
        bus_wdata_q <= darr[{dvic_cur, set_q, beat_d}];
      end else if (st_d == ST_FILL) begin
        bus_addr_q <= {ptag_q, set_q, beat_d, 2'b00};
      end else if (st_d == ST_UNC) begin
        bus_we_q <= we_q;
        bus_be_q <= be_q;
        bus_addr_q <= {ptag_q, set_q, word_q, 2'b00};
        bus_wdata_q <= wdata_q;
      end
    end
  end

  assign ready_out = ready_q;
  assign if_ack_out = if_ack_q;
  assign if_data_out = if_data_q;
  assign ls_ack_out = ls_ack_q;
  assign ls_rdata_out = ls_rdata_q;
  assign ls_perr_out = ls_perr_q;
  assign cm_ack_out = cm_ack_q;
  assign cm_hit_out = cm_hit_q;
  assign bus_req_out = bus_req_q;
  assign bus_we_out = bus_we_q;
  assign bus_be_out = bus_be_q;
  assign bus_addr_out = bus_addr_q;
  assign bus_wdata_out = bus_wdata_q;
endmodule // l1c_split_cache

// [core/l1c_tag_array.sv]
// l1c_tag_array: tag, valid and lock store of one cache, with hit compare and victim pick.
// Assumes lookup set and tag are stable registers; replacement bits come from outside.
`timescale 1ns/1ps
`include "l1c_params.svh"
module l1c_tag_array #(
  parameter int WAYS = 4
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  l1c_tag_if.array tif
);
  import l1c_pkg::*;
  localparam int WW = (WAYS > 1) ? $clog2(WAYS) : 1;
  localparam int SETS = `L1C_SETS;

  l1c_tag_t tag_mem [SETS][WAYS];
  logic [WAYS-1:0] vld_q [SETS];
  logic [WAYS-1:0] lck_q [SETS];
  logic [WAYS-1:0] match;
  logic [WAYS-1:0] vld_row;
  logic [WAYS-1:0] free;
  logic [WAYS-1:0] cand;

  function automatic logic [WW-1:0] first_one(input logic [WAYS-1:0] v);
    first_one = '0;
    for (int i = WAYS - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_one = WW'(i);
      end
    end
  endfunction

  assign vld_row = vld_q[tif.rd_set];
  assign free = ~lck_q[tif.rd_set];

  for (genvar g = 0; g < WAYS; g++) begin : g_cmp
    assign match[g] = vld_row[g] && (tag_mem[tif.rd_set][g] == tif.rd_tag);
  end

  assign tif.hit = |match;
  assign tif.hit_way = first_one(match);

  // Invalid ways first, then not recently used, never a locked way
  always_comb begin
    cand = free & ~vld_row;
    if (cand == '0) begin
      cand = free & ~tif.use_bits;
    end
    if (cand == '0) begin
      cand = free;
    end
  end

  assign tif.vic_ok = |free;
  assign tif.vic_way = first_one(cand);
  assign tif.vic_valid = vld_row[tif.vic_way];
  assign tif.vic_tag = tag_mem[tif.rd_set][tif.vic_way];

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int s = 0; s < SETS; s++) begin
        vld_q[s] <= '0;
        lck_q[s] <= '0;
      end
    end else begin
      if (tif.wr_en) begin
        vld_q[tif.wr_set][tif.wr_way] <= 1'b1;
        lck_q[tif.wr_set][tif.wr_way] <= 1'b0;
      end
      // Lock state changes only on a line that is present
      if (tif.lk_en && tif.hit) begin
        lck_q[tif.rd_set][tif.hit_way] <= tif.lk_val;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (tif.wr_en) begin
      tag_mem[tif.wr_set][tif.wr_way] <= tif.wr_tag;
    end
  end
endmodule // l1c_tag_array

// [core/l1c_tag_if.sv]
// l1c_tag_if: lookup, victim and update signals between cache control and one tag array.
// Assumes the controller drives lookup and update, the array answers combinationally.
`timescale 1ns/1ps
`include "l1c_params.svh"
interface l1c_tag_if #(parameter int WAYS = 4) ();
  import l1c_pkg::*;
  localparam int WW = (WAYS > 1) ? $clog2(WAYS) : 1;
  l1c_set_t rd_set;
  l1c_tag_t rd_tag;
  logic [WAYS-1:0] use_bits;
  logic hit;
  logic [WW-1:0] hit_way;
  logic vic_ok;
  logic vic_valid;
  logic [WW-1:0] vic_way;
  l1c_tag_t vic_tag;
  logic wr_en;
  logic [WW-1:0] wr_way;
  l1c_set_t wr_set;
  l1c_tag_t wr_tag;
  logic lk_en;
  logic lk_val;
  modport ctrl (output rd_set, rd_tag, use_bits, wr_en, wr_way, wr_set, wr_tag, lk_en, lk_val,
                input hit, hit_way, vic_ok, vic_valid, vic_way, vic_tag);
  modport array (input rd_set, rd_tag, use_bits, wr_en, wr_way, wr_set, wr_tag, lk_en, lk_val,
                 output hit, hit_way, vic_ok, vic_valid, vic_way, vic_tag);
endinterface

// [verif/l1c_bus_model.sv]
// l1c_bus_model: word-wide system memory answering the cache's bus requests.
// Assumes one word request at a time, held until the one-cycle ack it returns.
`timescale 1ns/1ps
module l1c_bus_model (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic req_in,
  input wire logic we_in,
  input wire logic [3:0] be_in,
  input wire l1c_pkg::l1c_word_t addr_in,
  input wire l1c_pkg::l1c_word_t wdata_in,
  output logic ack_out,
  output l1c_pkg::l1c_word_t rdata_out
);
  import l1c_pkg::*;
  l1c_word_t mem_q [l1c_word_t];
  l1c_word_t w;
  logic [7:0] lf_q;
  logic [1:0] wait_q;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ack_out <= 1'b0;
      wait_q <= 2'h0;
      lf_q <= 8'h5b;
      rdata_out <= 32'h0;
    end else begin
      lf_q <= {lf_q[6:0], lf_q[7] ^ lf_q[5] ^ lf_q[4] ^ lf_q[3]};
      // Data line toggles outside acks so stale data never matches
      rdata_out <= ~rdata_out;
      ack_out <= 1'b0;
      if (ack_out || !req_in) begin
        wait_q <= lf_q[1:0];
      end else if (wait_q != 2'h0) begin
        wait_q <= wait_q - 2'h1;
      end else begin
        w = mem_q.exists(addr_in) ? mem_q[addr_in] : addr_in ^ 32'h3c5a96e1;
        for (int b = 0; b < 4; b++) if (we_in && be_in[b]) w[8*b+:8] = wdata_in[8*b+:8];
        mem_q[addr_in] = w;
        rdata_out <= we_in ? ~rdata_out : w;
        ack_out <= 1'b1;
      end
    end
  end
endmodule // l1c_bus_model

// [verif/l1c_split_cache_asserts.sv]
// l1c_split_cache_asserts: port-level timing checks of the split cache.
// Assumes binding to l1c_split_cache; sees only its ports.
`timescale 1ns/1ps
module l1c_split_cache_asserts (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ready_out,
  input wire logic if_req_in,
  input wire logic ls_req_in,
  input wire logic cm_req_in,
  input wire logic if_ack_out,
  input wire logic ls_ack_out,
  input wire logic cm_ack_out,
  input wire logic bus_req_out,
  input wire logic bus_we_out,
  input wire logic [3:0] bus_be_out,
  input wire l1c_pkg::l1c_word_t bus_addr_out,
  input wire l1c_pkg::l1c_word_t bus_wdata_out,
  input wire logic bus_ack_in
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  property p_take;
    ready_out && (if_req_in || ls_req_in || cm_req_in) |=> !ready_out;
  endproperty
  a_take: assert property (p_take) else $error("ready held after request");
  property p_cm;
    ready_out && cm_req_in |-> ##[2:4] cm_ack_out;
  endproperty
  a_cm: assert property (p_cm) else $error("maintenance ack late");
  property p_pulse;
    (if_ack_out || ls_ack_out || cm_ack_out) |=> !(if_ack_out || ls_ack_out || cm_ack_out);
  endproperty
  a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
  property p_one;
    $onehot0({if_ack_out, ls_ack_out, cm_ack_out});
  endproperty
  a_one: assert property (p_one) else $error("two acks at once");
  property p_hold;
    bus_req_out && !bus_ack_in |=> bus_req_out && $stable(bus_addr_out)
      && $stable(bus_wdata_out) && $stable(bus_we_out);
  endproperty
  a_hold: assert property (p_hold) else $error("bus request changed before ack");
  property p_busy;
    bus_req_out |-> !ready_out;
  endproperty
  a_busy: assert property (p_busy) else $error("ready during bus traffic");
  property p_rdbe;
    bus_req_out && !bus_we_out |-> bus_be_out == 4'hf;
  endproperty
  a_rdbe: assert property (p_rdbe) else $error("partial bus read");
  property p_word;
    bus_req_out |-> bus_addr_out[1:0] == 2'h0;
  endproperty
  a_word: assert property (p_word) else $error("unaligned bus address");
  // Write-back of a full line is followed at once by the refill reads
  property p_wb;
    bus_req_out && bus_we_out && bus_ack_in && bus_addr_out[3:2] == 2'h3
      |=> bus_req_out && !bus_we_out && bus_addr_out[3:2] == 2'h0;
  endproperty
  a_wb: assert property (p_wb) else $error("refill not after write-back");
  c_wb: cover property (bus_req_out && bus_we_out && bus_ack_in);
  c_cm: cover property (cm_ack_out);
  c_if: cover property (if_ack_out);
endmodule // l1c_split_cache_asserts
bind l1c_split_cache l1c_split_cache_asserts chk_u (.*);

// [verif/l1c_split_cache_test.sv]
// l1c_split_cache_test: directed lock tests and random traffic for the split cache.
// Assumes l1c_bus_model as system memory and the bound checker.
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module l1c_split_cache_test;
  import l1c_pkg::*;
  logic clk_in = 1'b0, rstn_in = 1'b0;
  logic if_req_in = 1'b0, ls_req_in = 1'b0, cm_req_in = 1'b0, ls_we_in = 1'b0;
  logic cm_dside_in = 1'b0, cm_lock_in = 1'b0;
  logic [3:0] ls_be_in = 4'hf;
  l1c_word_t va = 32'h0, pa = 32'h0, ls_wdata_in = 32'h0, seed = 32'he;
  logic ready_out, if_ack_out, ls_ack_out, ls_perr_out, cm_ack_out, cm_hit_out;
  logic bus_req_out, bus_we_out, bus_ack_in;
  logic [3:0] bus_be_out;
  l1c_word_t if_data_out, ls_rdata_out, bus_addr_out, bus_wdata_out, bus_rdata_in;
  l1c_word_t sh [l1c_word_t];
  int err_count = 0, compares = 0, acks = 0, n0;
  initial forever #12.5 clk_in = ~clk_in;
  always @(posedge clk_in) if (bus_ack_in === 1'b1) acks++;
  l1c_split_cache dut_u (.if_va_in(va), .ls_va_in(va), .cm_va_in(va), .if_pa_in(pa),
    .ls_pa_in(pa), .cm_pa_in(pa), .*);
  l1c_bus_model bus_u (.clk_in(clk_in), .rstn_in(rstn_in), .req_in(bus_req_out),
    .we_in(bus_we_out), .be_in(bus_be_out), .addr_in(bus_addr_out),
    .wdata_in(bus_wdata_out), .ack_out(bus_ack_in), .rdata_out(bus_rdata_in));
  function automatic l1c_word_t xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic l1c_word_t mem_val(input l1c_word_t a);
    return sh.exists(a) ? sh[a] : a ^ 32'h3c5a96e1;
  endfunction
  function automatic l1c_word_t merge(input l1c_word_t o, n, input logic [3:0] be);
    for (int b = 0; b < 4; b++) if (be[b]) o[8*b+:8] = n[8*b+:8];
    return o;
  endfunction
  // Kinds: 0 fetch, 1 load, 2 store, 3 lock, 4 unlock
  task automatic op(input int k, input l1c_word_t a, input logic d = 1'b1,
    input logic h = 1'b0, input l1c_word_t wd = 32'h0, input logic [3:0] be = 4'hf);
    int n;
    n = 0;
    while (ready_out !== 1'b1) @(negedge clk_in);
    @(posedge clk_in);
    pa <= a;
    va <= (xs() & 32'hfffffc00) | (a & 32'h3ff);
    if_req_in <= (k == 0);
    ls_req_in <= (k == 1 || k == 2);
    ls_we_in <= (k == 2);
    cm_req_in <= (k > 2);
    cm_lock_in <= (k == 3);
    cm_dside_in <= d;
    ls_wdata_in <= wd;
    ls_be_in <= be;
    @(posedge clk_in);
    {if_req_in, ls_req_in, cm_req_in} <= 3'h0;
    do begin
      @(negedge clk_in);
      n++;
    end while (n < 300 && (k == 0 ? if_ack_out : k < 3 ? ls_ack_out : cm_ack_out) !== 1'b1);
    `CHK(n < 300, 1'b1)
    if (k == 0) `CHK(if_data_out, a ^ 32'h3c5a96e1)
    if (k == 1) `CHK(ls_rdata_out, mem_val(a))
    if (k == 1) `CHK(ls_perr_out, 1'b0)
    if (k > 2) `CHK(cm_hit_out, h)
    if (k == 2) sh[a] = merge(mem_val(a), wd, be);
  endtask
  task automatic stop_test();
    $display("counts: %0d compares, %0d mismatches", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #(25 * 40000);
    err_count++;
    stop_test();
  end
  initial begin
    l1c_word_t r;
    repeat (8) @(posedge clk_in);
    rstn_in <= 1'b1;
    op(0, 32'h20000040);
    op(0, 32'h20000048);
    op(3, 32'h20000040, 1'b0, 1'b1);
    op(4, 32'h20000040, 1'b0, 1'b1);
    op(4, 32'h20000440, 1'b0, 1'b0);
    $display("test fetch and line lock done");
    for (int t = 0; t < 4; t++) op(1, 32'h30000050 + (t << 10));
    for (int t = 0; t < 4; t++) op(3, 32'h30000050 + (t << 10), 1'b1, 1'b1);
    op(2, 32'h30000050, 1'b1, 1'b0, xs(), 4'h6);
    n0 = acks;
    op(1, 32'h30000050);
    `CHK(acks - n0, 0)
    n0 = acks;
    op(1, 32'h30001050);
    `CHK(acks - n0, 1)
    n0 = acks;
    op(1, 32'h30000450);
    `CHK(acks - n0, 0)
    op(4, 32'h30001050, 1'b1, 1'b0);
    for (int t = 0; t < 4; t++) op(4, 32'h30000050 + (t << 10), 1'b1, 1'b1);
    $display("test data lock done");
    for (int i = 0; i < 400; i++) begin
      r = xs();
      if (r[0]) op(0, 32'h20000000 | (r & 32'h1c3c));
      else op(r[1] ? 2 : 1, 32'h10000000 | (r & 32'h1c3c), 1'b1, 1'b0, xs(), r[7:4] | 4'h1);
    end
    $display("test random traffic done");
    stop_test();
  end
endmodule // l1c_split_cache_test
